//--- hw/sector_ecc_params.svh
// Constants for the sector error-protection block.
`ifndef SECTOR_ECC_PARAMS_SVH
`define SECTOR_ECC_PARAMS_SVH
`define SRE_SECTOR_BYTES 512
`define SRE_CHECK_BYTES 18
`define SRE_CRC_BYTES 2
`define SRE_LANES 9
`define SRE_LANES_PER_ROW 4'h3
`define SRE_ROW_LAST 2'h2
`define SRE_SPAN_ROUND 9'h017
`define SRE_BITS_PER_ROWBYTE 9'h018
`define SRE_MAX_SPAN 9'h003
`define SRE_GF_POLY 8'h1d
`define SRE_CRC_POLY 16'h1021
`define SRE_CRC_INIT 16'hffff
`define SRE_FIFO_DEPTH 16
`define SRE_FIFO_MARGIN 2
`endif

//--- hw/sector_ecc_pkg.sv
// Types shared by the sector error-protection block.
package sector_ecc_pkg;
  typedef enum logic [9:0] {
    ST_IDLE    = 10'h001,
    ST_W_DATA  = 10'h002,
    ST_W_CHECK = 10'h004,
    ST_W_CRC   = 10'h008,
    ST_R_DATA  = 10'h010,
    ST_R_CHECK = 10'h020,
    ST_R_CRC   = 10'h040,
    ST_R_EVAL  = 10'h080,
    ST_R_EMIT  = 10'h100,
    ST_DONE    = 10'h200
  } ecc_state_t;

  typedef struct packed {
    logic data_error;
    logic corrected;
    logic unrecoverable;
  } sector_status_t;
endpackage

//--- hw/byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides and an occupancy count.
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_in,                       // System clock.
  input wire logic sys_rst_in,                       // Asynchronous reset, active high.
  input wire logic in_valid_in,                      // Write side offers a word.
  output logic in_ready_out,                         // FIFO has room.
  input wire logic [WIDTH-1:0] in_data_in,           // Word written.
  output logic out_valid_out,                        // FIFO holds a word.
  input wire logic out_ready_in,                     // Read side takes the word.
  output logic [WIDTH-1:0] out_data_out,             // Word at the head.
  output logic [$clog2(DEPTH+1)-1:0] count_out       // Words held.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [$clog2(DEPTH+1)-1:0] count_reg;
  logic push;
  logic pop;

  // Full and empty follow the count alone, so they never disagree with it.
  assign in_ready_out = (count_reg != ($clog2(DEPTH+1))'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem[rd_ptr_reg];
  assign count_out = count_reg;
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Storage is written only on an accepted push.
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end
  end
endmodule

//--- hw/sector_ecc.sv
// Sector check-field generator, checker and corrector with CRC backup.
`include "sector_ecc_params.svh"
module sector_ecc #(
  parameter int SECTOR_BYTES = `SRE_SECTOR_BYTES,
  parameter int FIFO_DEPTH = `SRE_FIFO_DEPTH
) (
  input wire logic clk_sys_in,                          // System clock, 40 MHz.
  input wire logic sys_rst_in,                          // Asynchronous reset, active high.
  input wire logic start_in,                            // Pulse in idle starts one sector.
  input wire logic read_mode_in,                        // High for read, low for write.
  input wire logic disable_correction_bit_in,           // High turns correction off.
  input wire logic [7:0] span_bits_in,                  // Correction span, bits per sector.
  input wire logic in_valid_in,                         // Input byte valid.
  input wire logic [7:0] in_data_in,                    // Input byte.
  output logic in_ready_out,                            // Block takes the input byte.
  output logic out_valid_out,                           // Output byte valid.
  output logic [7:0] out_data_out,                      // Output byte.
  input wire logic out_ready_in,                        // Sink takes the output byte.
  output logic busy_out,                                // A sector is in progress.
  output logic done_out,                                // One-cycle pulse at sector end.
  output sector_ecc_pkg::sector_status_t status_out     // Result of the last sector.
);
  localparam int CW = $clog2(SECTOR_BYTES);
  localparam int FCW = $clog2(FIFO_DEPTH + 1);

  sector_ecc_pkg::ecc_state_t state_reg;
  sector_ecc_pkg::sector_status_t status_reg;
  logic [CW-1:0] cnt_reg;
  logic [1:0] row_reg;
  logic [1:0] col_reg;
  logic [7:0] apow_reg;
  logic [7:0] par_reg [`SRE_LANES];
  logic [7:0] wgt_reg [`SRE_LANES];
  logic [`SRE_LANES-1:0] hit_reg;
  logic [7:0] buf_mem [SECTOR_BYTES];
  logic [15:0] crc_reg;
  logic [15:0] crc_stored_reg;
  logic [1:0] span_bytes_reg;
  logic dis_reg;
  logic rd_mode_reg;
  logic unrec_pre_reg;
  logic corr_en_reg;
  logic in_ready_reg;
  logic out_valid_reg;
  logic [7:0] out_data_reg;
  logic done_reg;
  logic busy_reg;
  logic take;
  logic push_valid;
  logic push;
  logic [7:0] push_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic [FCW-1:0] fifo_count;
  logic [3:0] lane;
  logic [7:0] emit_byte;
  logic fix;
  logic syn_any;
  logic over_span;
  logic [8:0] span_conv;
  logic accepting;

  // Multiply in GF(256) over the field polynomial, shift and add.
  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        p = p ^ x;
      end
      x = {x[6:0], 1'b0} ^ (x[7] ? `SRE_GF_POLY : 8'h00);
    end
    return p;
  endfunction

  // Advance the sector CRC by one byte, most significant bit first.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = {r[14:0], 1'b0} ^ (r[15] ? `SRE_CRC_POLY : 16'h0000);
    end
    return r;
  endfunction

  // Byte i sits in row i mod 3 and lane column (i div 3) mod 3, so any nine
  // contiguous bytes touch each of the nine lanes at most once.
  assign lane = 4'({2'b00, row_reg} * `SRE_LANES_PER_ROW + {2'b00, col_reg});
  assign accepting = (state_reg == sector_ecc_pkg::ST_W_DATA) || (state_reg == sector_ecc_pkg::ST_R_DATA) ||
                     (state_reg == sector_ecc_pkg::ST_R_CHECK) || (state_reg == sector_ecc_pkg::ST_R_CRC);
  assign take = in_valid_in && in_ready_reg;
  assign span_conv = ({1'b0, span_bits_in} + `SRE_SPAN_ROUND) / `SRE_BITS_PER_ROWBYTE;

  // A lane holding a single bad byte at position q gives wgt == par * alpha^q.
  assign fix = corr_en_reg && (par_reg[lane] != 8'h00) && (gmul(par_reg[lane], apow_reg) == wgt_reg[lane]);
  assign emit_byte = buf_mem[cnt_reg] ^ (fix ? par_reg[lane] : 8'h00);

  // Select what enters the FIFO in each phase.
  always_comb begin
    push_valid = 1'b0;
    push_data = in_data_in;
    unique case (1'b1)
      state_reg[1]: push_valid = take;
      state_reg[2]: begin
        push_valid = 1'b1;
        push_data = (cnt_reg < CW'(`SRE_LANES)) ? par_reg[cnt_reg[3:0]] : wgt_reg[4'(cnt_reg - CW'(`SRE_LANES))];
      end
      state_reg[3]: begin
        push_valid = 1'b1;
        push_data = cnt_reg[0] ? crc_reg[7:0] : crc_reg[15:8];
      end
      state_reg[8]: begin
        push_valid = 1'b1;
        push_data = emit_byte;
      end
      default: push_valid = 1'b0;
    endcase
  end
  assign push = push_valid && fifo_in_ready;

  // Syndrome screen: lanes per row with errors against the span, and lanes
  // whose two syndromes disagree about being zero, which no one-byte error gives.
  always_comb begin
    logic [1:0] n;
    n = 2'h0;
    syn_any = 1'b0;
    over_span = 1'b0;
    for (int r = 0; r < 3; r++) begin
      n = 2'h0;
      for (int c = 0; c < 3; c++) begin
        if (par_reg[r * 3 + c] != 8'h00) begin
          n = n + 2'h1;
        end
        if ((par_reg[r * 3 + c] == 8'h00) != (wgt_reg[r * 3 + c] == 8'h00)) begin
          over_span = 1'b1;
        end
        syn_any = syn_any | (par_reg[r * 3 + c] != 8'h00) | (wgt_reg[r * 3 + c] != 8'h00);
      end
      if (n > span_bytes_reg) begin
        over_span = 1'b1;
      end
    end
  end

  // Sequence through one sector; the FIFO stalls every emitting phase.
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= sector_ecc_pkg::ST_IDLE;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end else begin
      unique case (1'b1)
        state_reg[0]: if (start_in) begin
          state_reg <= read_mode_in ? sector_ecc_pkg::ST_R_DATA : sector_ecc_pkg::ST_W_DATA;
          cnt_reg <= '0;
          busy_reg <= 1'b1; // Own flop, so the port never shows decode glitches.
        end
        state_reg[1], state_reg[4]: if (take) begin
          cnt_reg <= (cnt_reg == CW'(SECTOR_BYTES - 1)) ? '0 : cnt_reg + 1'b1;
          if (cnt_reg == CW'(SECTOR_BYTES - 1)) begin
            state_reg <= state_reg[1] ? sector_ecc_pkg::ST_W_CHECK : sector_ecc_pkg::ST_R_CHECK;
          end
        end
        state_reg[2], state_reg[5]: if (state_reg[2] ? push : take) begin
          cnt_reg <= (cnt_reg == CW'(`SRE_CHECK_BYTES - 1)) ? '0 : cnt_reg + 1'b1;
          if (cnt_reg == CW'(`SRE_CHECK_BYTES - 1)) begin
            state_reg <= state_reg[2] ? sector_ecc_pkg::ST_W_CRC : sector_ecc_pkg::ST_R_CRC;
          end
        end
        state_reg[3], state_reg[6]: if (state_reg[3] ? push : take) begin
          cnt_reg <= (cnt_reg == CW'(`SRE_CRC_BYTES - 1)) ? '0 : cnt_reg + 1'b1;
          if (cnt_reg == CW'(`SRE_CRC_BYTES - 1)) begin
            state_reg <= state_reg[3] ? sector_ecc_pkg::ST_DONE : sector_ecc_pkg::ST_R_EVAL;
          end
        end
        state_reg[7]: state_reg <= sector_ecc_pkg::ST_R_EMIT;
        state_reg[8]: if (push) begin
          cnt_reg <= (cnt_reg == CW'(SECTOR_BYTES - 1)) ? '0 : cnt_reg + 1'b1;
          if (cnt_reg == CW'(SECTOR_BYTES - 1)) begin
            state_reg <= sector_ecc_pkg::ST_DONE;
          end
        end
        state_reg[9]: begin
          state_reg <= sector_ecc_pkg::ST_IDLE;
          busy_reg <= 1'b0;
        end
        default: begin
          state_reg <= sector_ecc_pkg::ST_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // Row, lane column and alpha^q follow each data byte taken or emitted.
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      row_reg <= 2'h0;
      col_reg <= 2'h0;
      apow_reg <= 8'h01;
    end else if ((state_reg[0] && start_in) || state_reg[7]) begin
      row_reg <= 2'h0;
      col_reg <= 2'h0;
      apow_reg <= 8'h01;
    end else if (((state_reg[1] || state_reg[4]) && take) || (state_reg[8] && push)) begin
      row_reg <= (row_reg == `SRE_ROW_LAST) ? 2'h0 : row_reg + 2'h1;
      if (row_reg == `SRE_ROW_LAST) begin
        col_reg <= (col_reg == `SRE_ROW_LAST) ? 2'h0 : col_reg + 2'h1;
        if (col_reg == `SRE_ROW_LAST) begin
          apow_reg <= gmul(apow_reg, 8'h02);
        end
      end
    end
  end

  // Parity and weighted sums per lane; on read the stored field folds in, leaving syndromes.
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int l = 0; l < `SRE_LANES; l++) begin
        par_reg[l] <= 8'h00;
        wgt_reg[l] <= 8'h00;
      end
    end else if (state_reg[0] && start_in) begin
      for (int l = 0; l < `SRE_LANES; l++) begin
        par_reg[l] <= 8'h00;
        wgt_reg[l] <= 8'h00;
      end
    end else if ((state_reg[1] || state_reg[4]) && take) begin
      par_reg[lane] <= par_reg[lane] ^ in_data_in;
      wgt_reg[lane] <= wgt_reg[lane] ^ gmul(in_data_in, apow_reg);
    end else if (state_reg[5] && take) begin
      if (cnt_reg < CW'(`SRE_LANES)) begin
        par_reg[cnt_reg[3:0]] <= par_reg[cnt_reg[3:0]] ^ in_data_in;
      end else begin
        wgt_reg[4'(cnt_reg - CW'(`SRE_LANES))] <= wgt_reg[4'(cnt_reg - CW'(`SRE_LANES))] ^ in_data_in;
      end
    end
  end

  // Read data waits here until the check field has arrived.
  always_ff @(posedge clk_sys_in) begin
    if (state_reg[4] && take) begin
      buf_mem[cnt_reg] <= in_data_in;
    end
  end

  // CRC runs over data going in, then restarts over corrected data going out.
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      crc_reg <= `SRE_CRC_INIT;
      crc_stored_reg <= 16'h0000;
    end else if ((state_reg[0] && start_in) || state_reg[7]) begin
      crc_reg <= `SRE_CRC_INIT;
    end else if ((state_reg[1] || state_reg[4]) && take) begin
      crc_reg <= crc_step(crc_reg, in_data_in);
    end else if (state_reg[8] && push) begin
      crc_reg <= crc_step(crc_reg, emit_byte);
    end else if (state_reg[6] && take) begin
      crc_stored_reg <= {crc_stored_reg[7:0], in_data_in};
    end
  end

  // Sector setup and the verdict taken once the syndromes are complete.
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      span_bytes_reg <= 2'h0;
      dis_reg <= 1'b0;
      rd_mode_reg <= 1'b0;
      unrec_pre_reg <= 1'b0;
      corr_en_reg <= 1'b0;
      hit_reg <= '0;
    end else if (state_reg[0] && start_in) begin
      span_bytes_reg <= (span_conv > `SRE_MAX_SPAN) ? 2'(`SRE_MAX_SPAN) : span_conv[1:0];
      dis_reg <= disable_correction_bit_in;
      rd_mode_reg <= read_mode_in;
      hit_reg <= '0;
      corr_en_reg <= 1'b0;
    end else if (state_reg[7]) begin
      // Correction runs only if enabled, the span is nonzero and every row fits it.
      unrec_pre_reg <= syn_any && (over_span || dis_reg || span_bytes_reg == 2'h0);
      corr_en_reg <= syn_any && !over_span && !dis_reg && span_bytes_reg != 2'h0;
    end else if (state_reg[8] && push && fix) begin
      hit_reg[lane] <= 1'b1;
    end
  end

  // Status stands until the next sector; a lane never matched or a CRC miss is fatal.
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      status_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= state_reg[9];
      if (state_reg[0] && start_in) begin
        status_reg <= '0;
      end else if (state_reg[9] && rd_mode_reg) begin
        status_reg.data_error <= syn_any;
        status_reg.unrecoverable <= unrec_pre_reg || (crc_reg != crc_stored_reg) ||
                                    (corr_en_reg && (hit_reg != lane_err_mask()));
        status_reg.corrected <= corr_en_reg && (crc_reg == crc_stored_reg) && (hit_reg == lane_err_mask());
      end
    end
  end

  // Lanes whose parity syndrome shows an error.
  function automatic logic [`SRE_LANES-1:0] lane_err_mask();
    logic [`SRE_LANES-1:0] m;
    m = '0;
    for (int l = 0; l < `SRE_LANES; l++) begin
      m[l] = (par_reg[l] != 8'h00);
    end
    return m;
  endfunction

  // Ready is registered, so it drops a cycle early with a FIFO margin to spare.
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      in_ready_reg <= 1'b0;
    end else begin
      in_ready_reg <= accepting && !(take && (cnt_reg == CW'(SECTOR_BYTES - 1) || state_reg[6] ||
                      (state_reg[5] && cnt_reg == CW'(`SRE_CHECK_BYTES - 1)))) &&
                      (fifo_count < FCW'(FIFO_DEPTH - `SRE_FIFO_MARGIN));
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(push_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(push_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data),
    .count_out(fifo_count)
  );

  // Output register stage keeps every port on a flip-flop.
  assign fifo_out_ready = !out_valid_reg || out_ready_in;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= 8'h00;
    end else if (fifo_out_ready) begin
      out_valid_reg <= fifo_out_valid;
      out_data_reg <= fifo_out_data;
    end
  end

  assign in_ready_out = in_ready_reg;
  assign out_valid_out = out_valid_reg;
  assign out_data_out = out_data_reg;
  assign busy_out = busy_reg;
  assign done_out = done_reg;
  assign status_out = status_reg;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  AST_CHECK_LEN: assert property (state_reg[2] && push && cnt_reg == CW'(`SRE_CHECK_BYTES - 1) |=> state_reg[3])
    else $error("check field not 18 bytes");
  AST_DATA_ERR: assert property (state_reg[9] && rd_mode_reg && syn_any |=> status_reg.data_error)
    else $error("mismatch not flagged");
  AST_DCR_NOFIX: assert property (dis_reg && state_reg[8] |-> !fix)
    else $error("correction while disabled");
  AST_ROW_RANGE: assert property (row_reg <= 2'h2 && col_reg <= 2'h2)
    else $error("row or lane out of range");
  AST_SPAN_MAX: assert property (state_reg[0] && start_in && span_bits_in == 8'h48 |=> span_bytes_reg == 2'h3)
    else $error("72-bit span not three bytes per row");
  AST_SPAN_HOLD: assert property (state_reg[8] |-> $stable(span_bytes_reg))
    else $error("span changed during correction");
  AST_WIDE_BURST: assert property (state_reg[7] && syn_any && over_span |=> ##1 !fix [*3])
    else $error("wide burst corrected");
  AST_SPAN_CONV: assert property (state_reg[0] && start_in && span_bits_in == 8'h19 |=> span_bytes_reg == 2'h2)
    else $error("span rounding wrong");
  AST_CRC_LEN: assert property (state_reg[3] && push && cnt_reg == CW'(`SRE_CRC_BYTES - 1) |=> state_reg[9] ##1 done_reg)
    else $error("crc not two bytes");
  AST_RECHECK: assert property (state_reg[9] && rd_mode_reg && crc_reg != crc_stored_reg
                                |=> status_reg.unrecoverable && !status_reg.corrected)
    else $error("crc recheck ignored");
  AST_SPAN_ZERO: assert property (state_reg[0] && start_in && span_bits_in == 8'h00 |=> span_bytes_reg == 2'h0)
    else $error("zero span not detection only");
  AST_SPAN_CLIP: assert property (state_reg[0] && start_in && span_bits_in > 8'h48 |=> span_bytes_reg == 2'h3)
    else $error("span not capped");

  COV_WRITE: cover property (state_reg[3] ##1 state_reg[9]);
  COV_CORRECTED: cover property (state_reg[9] && rd_mode_reg ##1 status_reg.corrected);
  COV_UNREC: cover property (state_reg[9] && rd_mode_reg ##1 status_reg.unrecoverable);
endmodule

//--- bench/sector_sink.sv
// Behavioural sink on the output byte stream: stalls at random and records every byte it accepts.
module sector_sink (
  input wire logic clk_sys_in,         // System clock.
  input wire logic sys_rst_in,         // Reset, active high.
  input wire logic out_valid_in,       // Byte offered by the block.
  input wire logic [7:0] out_data_in,  // Byte value.
  output logic out_ready_out           // Sink accepts the byte.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  int seed = 32'h0000_de6b;
  initial out_ready_out = 1'b0;
  // Take the byte on the accepting edge, then redraw ready just after it so the FIFO sees back-pressure.
  always @(posedge clk_sys_in) begin
    if (!sys_rst_in && out_valid_in && out_ready_out) got.push_back(out_data_in);
    #1 out_ready_out = !sys_rst_in && (($random(seed) & 3) != 0);
  end
endmodule

//--- bench/sector_ecc_bench.sv
// Self-checking bench for the sector check-field generator and corrector.
module sector_ecc_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NB = 18;
  logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, start_in = 1'b0, read_mode_in = 1'b0;
  logic disable_correction_bit_in = 1'b0, in_valid_in = 1'b0;
  logic [7:0] span_bits_in = 8'h00, in_data_in = 8'h00, out_data_out;
  logic in_ready_out, out_valid_out, out_ready_in, busy_out, done_out;
  sector_ecc_pkg::sector_status_t status_out, st;
  int seed = 32'h0000_de6b, fail_count = 0, compares = 0;
  logic [7:0] dat[NB], trail[$], feed[$];

  sector_ecc #(.SECTOR_BYTES(NB), .FIFO_DEPTH(16)) sector_ecc_i (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .start_in(start_in), .read_mode_in(read_mode_in),
    .disable_correction_bit_in(disable_correction_bit_in), .span_bits_in(span_bits_in),
    .in_valid_in(in_valid_in), .in_data_in(in_data_in), .in_ready_out(in_ready_out),
    .out_valid_out(out_valid_out), .out_data_out(out_data_out), .out_ready_in(out_ready_in),
    .busy_out(busy_out), .done_out(done_out), .status_out(status_out));
  sector_sink sector_sink_i (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .out_valid_in(out_valid_out), .out_data_in(out_data_out), .out_ready_out(out_ready_in));

  initial begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  // Multiply by alpha in the check field's byte field.
  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1d : 8'h00);
  endfunction
  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r = 8'h00;
    for (int k = 0; k < 8; k++) begin
      if (b[k]) r ^= a;
      a = xt(a);
    end
    return r;
  endfunction

  // Nine lane parities, nine weighted lane sums, then the CRC high byte first.
  task automatic calc_trail();
    logic [7:0] par[9], wsum[9], pw;
    logic [15:0] crc;
    int ln;
    pw = 8'h01;
    crc = 16'hffff;
    for (int l = 0; l < 9; l++) begin
      par[l] = 8'h00;
      wsum[l] = 8'h00;
    end
    for (int i = 0; i < NB; i++) begin
      if (i > 0 && i % 9 == 0) pw = xt(pw);
      ln = (i % 3) * 3 + (i / 3) % 3;
      par[ln] ^= dat[i];
      wsum[ln] ^= gmul(dat[i], pw);
      crc ^= {dat[i], 8'h00};
      repeat (8) crc = crc[15] ? ({crc[14:0], 1'b0} ^ 16'h1021) : {crc[14:0], 1'b0};
    end
    trail = {};
    for (int l = 0; l < 9; l++) trail.push_back(par[l]);
    for (int l = 0; l < 9; l++) trail.push_back(wsum[l]);
    trail.push_back(crc[15:8]);
    trail.push_back(crc[7:0]);
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // One sector: start, stream the feed with random gaps, then wait for the end pulse and the output.
  task automatic run(input logic rd, input logic dis, input logic [7:0] span, input int nout);
    int n;
    sector_sink_i.got.delete();
    @(posedge clk_sys_in);
    #1 start_in = 1'b1;
    read_mode_in = rd;
    disable_correction_bit_in = dis;
    span_bits_in = span;
    @(posedge clk_sys_in);
    #1 start_in = 1'b0;
    check(busy_out, 1'b1, "busy after start");
    span_bits_in = 8'($random(seed));
    foreach (feed[k]) begin
      if ($random(seed) & 1) begin
        in_valid_in = 1'b0;
        @(posedge clk_sys_in);
        #1;
      end
      in_valid_in = 1'b1;
      in_data_in = feed[k];
      n = 0;
      // Ready is registered, so its settled value here is what the next edge samples.
      while (in_ready_out !== 1'b1 && n < 200) begin
        @(posedge clk_sys_in);
        #1 n++;
      end
      @(posedge clk_sys_in);
      #1;
    end
    in_valid_in = 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 2000) begin
      @(posedge clk_sys_in);
      #1 n++;
    end
    st = status_out;
    check(busy_out, 1'b0, "busy after end");
    @(posedge clk_sys_in);
    #1 check(done_out, 1'b0, "done longer than one cycle");
    n = 0;
    while (sector_sink_i.got.size() < nout && n < 500) begin
      @(posedge clk_sys_in);
      n++;
    end
    repeat (4) @(posedge clk_sys_in);
    check(16'(sector_sink_i.got.size()), 16'(nout), "output byte count");
  endtask

  task automatic write_case(input int w);
    for (int i = 0; i < NB; i++) dat[i] = (w == 0) ? 8'hff : 8'($random(seed));
    calc_trail();
    feed = {};
    foreach (dat[i]) feed.push_back(dat[i]);
    run(1'b0, 1'b0, 8'd72, NB + 20);
    check({13'h0000, st}, 16'h0000, "write status");
    foreach (dat[i]) check(sector_sink_i.got[i], dat[i], "write data");
    foreach (trail[i]) check(sector_sink_i.got[NB + i], trail[i], "check or crc byte");
  endtask

  // Read with a contiguous burst of len bytes at s; data is compared only when it should come out clean.
  task automatic rd_case(input int s, input int len, input logic [7:0] span, input logic dis,
    input logic crcbad, input logic [2:0] exp);
    for (int i = 0; i < NB; i++) dat[i] = 8'($random(seed));
    calc_trail();
    if (crcbad) trail[19] ^= 8'h01;
    feed = {};
    foreach (dat[i]) feed.push_back((i >= s && i < s + len) ? dat[i] ^ 8'(1 + {$random(seed)} % 255) : dat[i]);
    foreach (trail[i]) feed.push_back(trail[i]);
    run(1'b1, dis, span, NB);
    check({13'h0000, st}, {13'h0000, exp}, "read status");
    if (exp == 3'b000 || exp == 3'b110) foreach (dat[i]) check(sector_sink_i.got[i], dat[i], "read data");
  endtask

  task automatic give_verdict();
    $display("mismatches %0d of %0d compares", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Cuts a hang short well beyond the hundred or so cycles each of the fourteen sectors needs.
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (20) @(posedge clk_sys_in);
    #1 check({9'h000, in_ready_out, out_valid_out, busy_out, done_out, status_out}, 16'h0000, "reset outputs");
    sys_rst_in = 1'b0;
    for (int w = 0; w < 3; w++) write_case(w);
    rd_case(0, 0, 8'd72, 1'b0, 1'b0, 3'b000);
    rd_case(7, 1, 8'd72, 1'b0, 1'b0, 3'b110);
    rd_case(5, 9, 8'd72, 1'b0, 1'b0, 3'b110);
    rd_case(5, 9, 8'd48, 1'b0, 1'b0, 3'b101);
    rd_case(4, 10, 8'd72, 1'b0, 1'b0, 3'b101);
    rd_case(0, 4, 8'd24, 1'b0, 1'b0, 3'b101);
    rd_case(0, 4, 8'd25, 1'b0, 1'b0, 3'b110);
    rd_case(9, 9, 8'd200, 1'b0, 1'b0, 3'b110);
    rd_case(3, 1, 8'd0, 1'b0, 1'b0, 3'b101);
    rd_case(3, 1, 8'd72, 1'b1, 1'b0, 3'b101);
    rd_case(0, 0, 8'd72, 1'b0, 1'b1, 3'b001);
    give_verdict();
  end
endmodule
